// ### pkg/sio_pkg.sv
// Purpose: Constants and types of the I/O block.
// Assumes: 50 MHz system clock, 16-bit holding registers, word addresses.
// Notes: 32-bit values span two words, most significant word first.
package sio_pkg;

  localparam int SIO_CHANNELS = 7;
  localparam int SIO_INPUTS = 14;
  localparam int SIO_CLK_HZ = 50000000;

  // Register word addresses
  localparam logic [15:0] SIO_ADDR_IN1_LEVELS = 16'h0078;
  localparam logic [15:0] SIO_ADDR_IN2_LEVELS = 16'h0079;
  localparam logic [15:0] SIO_ADDR_OPEN_MAP = 16'h0082;
  localparam logic [15:0] SIO_ADDR_CLOSE_MAP = 16'h0083;
  localparam logic [15:0] SIO_ADDR_DEACT_MAP = 16'h0084;
  localparam logic [15:0] SIO_ADDR_ACT_MAP = 16'h0085;
  localparam logic [15:0] SIO_ADDR_FLOW_IN1 = 16'h36B0;
  localparam logic [15:0] SIO_ADDR_FLOW_IN2 = 16'h36C6;
  localparam logic [15:0] SIO_ADDR_CONS_IN1 = 16'h36E2;
  localparam logic [15:0] SIO_ADDR_CONS_IN2 = 16'h36F8;
  localparam logic [15:0] SIO_ADDR_OPS_IN1 = 16'h3714;
  localparam logic [15:0] SIO_ADDR_OPS_IN2 = 16'h372A;
  localparam logic [15:0] SIO_ADDR_HOURS_IN1 = 16'h3740;
  // Pulse weight slots
  localparam logic [15:0] SIO_ADDR_DETAIL_BASE = 16'h3778;
  localparam logic [15:0] SIO_DETAIL_STRIDE = 16'h0028;
  localparam logic [5:0] SIO_DETAIL_WEIGHT_IN1 = 6'h1E;
  localparam logic [5:0] SIO_DETAIL_WEIGHT_IN2 = 6'h1F;

  // Field layout and reset values
  localparam logic [6:0] SIO_CHANNEL_MASK = 7'h7F;
  localparam logic [15:0] SIO_LEVELS_RESET = 16'h0000;
  localparam logic [15:0] SIO_ORDER_RESET = 16'h0000;
  localparam logic [15:0] SIO_WEIGHT_RESET = 16'h000A;
  localparam logic [31:0] SIO_COUNTER_RESET = 32'h0000_0000;

  // Flow arithmetic
  localparam int SIO_SEC_PER_HOUR = 3600;
  localparam int SIO_MS_PER_SEC = 1000;
  localparam int SIO_HOURS_PER_DAY = 24;
  localparam int SIO_TIMEOUT_FACTOR = 3;
  localparam int SIO_TIMEOUT_MIN_S = 5;
  localparam logic [47:0] SIO_FLOW_SCALE = 48'(SIO_SEC_PER_HOUR * SIO_MS_PER_SEC);
  localparam logic [28:0] SIO_TIMEOUT_MIN_MS = 29'(SIO_TIMEOUT_MIN_S * SIO_MS_PER_SEC);
  localparam logic [26:0] SIO_DAY_MS =
    27'(SIO_HOURS_PER_DAY * SIO_SEC_PER_HOUR * SIO_MS_PER_SEC);
  localparam int SIO_MS_CYCLES = SIO_CLK_HZ / SIO_MS_PER_SEC;
  localparam logic [9:0] SIO_MS_PER_SEC_M1 = 10'(SIO_MS_PER_SEC - 1);
  localparam logic [11:0] SIO_SEC_PER_HOUR_M1 = 12'(SIO_SEC_PER_HOUR - 1);
  localparam logic [5:0] SIO_DIV_STEPS_M1 = 6'h2F;
  localparam logic [7:0] SIO_FLOAT_BIAS = 8'h7F;

  typedef enum logic {SIO_DIV_IDLE, SIO_DIV_RUN} sio_div_state_type;

endpackage : sio_pkg

// ### src/sio_chan_io.sv
// Purpose: Channel levels, orders, flow, meters and counters.
// Assumes: Single-cycle register port; synchronous inputs.
// Notes: One shared divider computes flow as float32.
`timescale 1ns/10ps

// Contract
// [R01] First-input levels of channels 1..7 on bits 0..6, upper bits reserved.
// [R02] Second-input levels of channels 1..7 on bits 0..6 of another word.
// [R03] Level bit is 0 with no input current, 1 with current.
// [R04] Read-write open and close order bitmaps, bit n is channel n+1.
// [R05] Read-write deactivate and activate order bitmaps with the same mapping.
// [R06] Writing 1 to an order bit requests it; many channels per write.
// [R07] Order bit cleared once acted upon; stays set with no product connected.
// [R08] Reserved order bits written as 1 are forced back to 0.
// [R09] Conflicting pair of orders on a channel causes no action.
// [R10] Flow is 3600 x weight over seconds between last two pulses, float32.
// [R11] Pulse weight defaults to 10 and is writable by the master.
// [R12] Flow cleared after 3 x last interval without pulse, at least 5 s.
// [R13] Flow cleared after 24 h without pulse and on supply loss.
// [R14] Consumption meter equals pulse count times pulse weight, unsigned 32-bit.
// [R15] Master may preset the pulse count; counting continues from it.
// [R16] Operation counter increments on each 1-to-0 transition of its input.
// [R17] First input running-hours counter accumulates only while input active.
// [R18] Flow registers every two addresses per channel, two bases.
// [R19] 32-bit values: MSW at lower address, read and written coherently.
module sio_chan_io
  import sio_pkg::*;
#(
  parameter int MS_CYCLES = SIO_MS_CYCLES
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Channel terminals
  input wire logic [6:0] i_first_sense_input,
  input wire logic [6:0] i_second_sense_input,
  input wire logic [6:0] i_product_present,
  input wire logic i_supply_loss,
  output logic [6:0] o_command_q,
  // Holding register port
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid
);

  // Pair decode: {hit, channel, low word}
  function automatic logic [4:0] sio_pair_dec(input logic [15:0] addr, input logic [15:0] base);
    logic [15:0] off;
    off = addr - base;
    return {(addr >= base) && (off < 16'h000E), off[3:1], off[0]};
  endfunction : sio_pair_dec

  // Unsigned to float32, mantissa truncated
  function automatic logic [31:0] sio_to_float(input logic [31:0] v);
    logic [4:0] p;
    logic [31:0] n;
    p = 5'h00;
    for (int k = 0; k < 32; k++) begin
      if (v[k]) begin
        p = 5'(k);
      end
    end
    n = v << (5'h1F - p);
    return (v == 32'h0000_0000) ? 32'h0000_0000 : {1'b0, SIO_FLOAT_BIAS + {3'h0, p}, n[30:8]};
  endfunction : sio_to_float

  // Lowest set bit of the pending vector
  function automatic logic [3:0] sio_first_set(input logic [13:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 13; k >= 0; k--) begin
      if (v[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction : sio_first_set

  // Sensed state
  logic [13:0] sense_reg;
  logic [13:0] prev_reg;
  logic [13:0] falling;
  // Orders
  logic [6:0] open_reg, close_reg, deact_reg, act_reg;
  logic [6:0] brk_conflict, load_conflict, brk_done, load_done;
  logic [6:0] q_reg;
  // Per-input counters
  logic [31:0] ops_reg [SIO_INPUTS];
  logic [15:0] weight_reg [SIO_INPUTS];
  logic [31:0] flow_reg [SIO_INPUTS];
  logic [26:0] cur_ms_reg [SIO_INPUTS];
  logic [26:0] last_ms_reg [SIO_INPUTS];
  logic [13:0] has_prev_reg;
  logic [13:0] pending_reg;
  logic [13:0] flow_clear;
  logic [13:0] new_interval;
  logic [31:0] hours_reg [SIO_CHANNELS];
  logic [11:0] secs_reg [SIO_CHANNELS];
  // Time base
  logic [15:0] ms_div_reg;
  logic [9:0] ms_cnt_reg;
  logic ms_tick, sec_tick;
  // Divider
  sio_div_state_type div_state_reg;
  logic [3:0] div_sel_reg;
  logic [5:0] div_cnt_reg;
  logic [47:0] div_dvd_reg;
  logic [26:0] div_dsr_reg;
  logic [27:0] div_rem_reg;
  logic [27:0] div_rem_shift;
  logic div_ge;
  logic div_start, div_last;
  logic [3:0] div_pick;
  logic [31:0] div_quot;
  // Register port
  logic [4:0] dec_flow1, dec_flow2, dec_cons1, dec_cons2, dec_ops1, dec_ops2, dec_hours;
  logic [15:0] det_off;
  logic [2:0] det_ch;
  logic [5:0] det_sub;
  logic det_hit;
  logic [15:0] wr_hi_reg, rd_lo_reg;
  logic [31:0] rd_val;
  logic rd_pair, rd_lsw, rd_single;
  logic [15:0] rd_word;
  logic [3:0] ops_idx;
  logic ops_hit, ops_lsw;
  logic [3:0] rd_idx;

  // Sense vector: first inputs 0..6, second inputs 7..13
  assign falling = prev_reg & ~sense_reg; // [R16]

  // Order execution per channel
  assign brk_conflict = open_reg & close_reg; // [R09]
  assign load_conflict = deact_reg & act_reg; // [R09]
  assign brk_done = (open_reg | close_reg) & i_product_present; // [R07]
  assign load_done = (deact_reg | act_reg) & i_product_present; // [R07]

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      open_reg <= 7'h00;
      close_reg <= 7'h00;
      deact_reg <= 7'h00;
      act_reg <= 7'h00;
      q_reg <= 7'h00;
    end else begin
      // Master write beats clear
      open_reg <= (i_reg_wr && i_reg_addr == SIO_ADDR_OPEN_MAP) ?
        i_reg_wdata[6:0] & SIO_CHANNEL_MASK : open_reg & ~brk_done; // [R04] [R06] [R08]
      close_reg <= (i_reg_wr && i_reg_addr == SIO_ADDR_CLOSE_MAP) ?
        i_reg_wdata[6:0] & SIO_CHANNEL_MASK : close_reg & ~brk_done; // [R04] [R07]
      deact_reg <= (i_reg_wr && i_reg_addr == SIO_ADDR_DEACT_MAP) ?
        i_reg_wdata[6:0] & SIO_CHANNEL_MASK : deact_reg & ~load_done; // [R05] [R08]
      act_reg <= (i_reg_wr && i_reg_addr == SIO_ADDR_ACT_MAP) ?
        i_reg_wdata[6:0] & SIO_CHANNEL_MASK : act_reg & ~load_done; // [R05] [R07]
      // Close/activate set Q, open/deactivate clear
      q_reg <= (q_reg
        | (close_reg & ~brk_conflict & i_product_present)
        | (act_reg & ~load_conflict & i_product_present))
        & ~(open_reg & ~brk_conflict & i_product_present)
        & ~(deact_reg & ~load_conflict & i_product_present); // [R06] [R09]
    end
  end

  assign o_command_q = q_reg;

  // ms and s enables
  assign ms_tick = (ms_div_reg == 16'(MS_CYCLES - 1));
  assign sec_tick = ms_tick && (ms_cnt_reg == SIO_MS_PER_SEC_M1);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ms_div_reg <= 16'h0000;
      ms_cnt_reg <= 10'h000;
    end else begin
      ms_div_reg <= ms_tick ? 16'h0000 : ms_div_reg + 16'h0001;
      if (ms_tick) begin
        ms_cnt_reg <= sec_tick ? 10'h000 : ms_cnt_reg + 10'h001;
      end
    end
  end

  // Flow timeouts and interval capture
  always_comb begin
    for (int i = 0; i < SIO_INPUTS; i++) begin
      logic [28:0] limit;
      limit = 29'(SIO_TIMEOUT_FACTOR) * {2'h0, last_ms_reg[i]};
      if (limit < SIO_TIMEOUT_MIN_MS) begin
        limit = SIO_TIMEOUT_MIN_MS; // [R12]
      end
      flow_clear[i] = i_supply_loss
        || (has_prev_reg[i] && ({2'h0, cur_ms_reg[i]} >= limit))
        || (cur_ms_reg[i] >= SIO_DAY_MS); // [R12] [R13]
      new_interval[i] = falling[i] && has_prev_reg[i] && !i_supply_loss;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sense_reg <= 14'h0000;
      prev_reg <= 14'h0000;
      has_prev_reg <= 14'h0000;
      for (int i = 0; i < SIO_INPUTS; i++) begin
        cur_ms_reg[i] <= 27'h0000000;
        last_ms_reg[i] <= 27'h0000000;
      end
    end else begin
      sense_reg <= {i_second_sense_input, i_first_sense_input}; // [R03]
      prev_reg <= sense_reg;
      for (int i = 0; i < SIO_INPUTS; i++) begin
        if (falling[i]) begin
          cur_ms_reg[i] <= 27'h0000000;
          has_prev_reg[i] <= !i_supply_loss;
          if (new_interval[i]) begin
            last_ms_reg[i] <= (cur_ms_reg[i] == 27'h0000000) ? 27'h0000001 : cur_ms_reg[i];
          end
        end else begin
          if (ms_tick && cur_ms_reg[i] < SIO_DAY_MS) begin
            cur_ms_reg[i] <= cur_ms_reg[i] + 27'h0000001;
          end
          if (i_supply_loss || cur_ms_reg[i] >= SIO_DAY_MS) begin
            has_prev_reg[i] <= 1'b0; // [R13]
          end
        end
      end
    end
  end

  // Shared divider: 3600000 x weight / interval in ms
  assign div_pick = sio_first_set(pending_reg);
  assign div_start = (div_state_reg == SIO_DIV_IDLE) && (pending_reg != 14'h0000);
  assign div_last = (div_state_reg == SIO_DIV_RUN) && (div_cnt_reg == SIO_DIV_STEPS_M1);
  assign div_rem_shift = {div_rem_reg[26:0], div_dvd_reg[47]};
  assign div_ge = div_rem_shift >= {1'b0, div_dsr_reg};
  assign div_quot = (div_dvd_reg[46:31] != 16'h0000) ? 32'hFFFF_FFFF :
    {div_dvd_reg[30:0], div_ge};

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      div_state_reg <= SIO_DIV_IDLE;
      div_sel_reg <= 4'h0;
      div_cnt_reg <= 6'h00;
      div_dvd_reg <= 48'h0;
      div_dsr_reg <= 27'h0000001;
      div_rem_reg <= 28'h0000000;
      pending_reg <= 14'h0000;
    end else begin
      // New interval beats take-up
      pending_reg <= (pending_reg & ~(div_start ? 14'(1) << div_pick : 14'h0000)
        & ~{14{i_supply_loss}}) | new_interval; // [R10]
      case (div_state_reg)
        SIO_DIV_IDLE: begin
          if (div_start) begin
            div_state_reg <= SIO_DIV_RUN;
            div_sel_reg <= div_pick;
            div_cnt_reg <= 6'h00;
            div_dvd_reg <= SIO_FLOW_SCALE * {32'h0, weight_reg[div_pick]}; // [R10]
            div_dsr_reg <= last_ms_reg[div_pick];
            div_rem_reg <= 28'h0000000;
          end
        end
        SIO_DIV_RUN: begin
          div_cnt_reg <= div_cnt_reg + 6'h01;
          div_rem_reg <= div_ge ? div_rem_shift - {1'b0, div_dsr_reg} : div_rem_shift;
          div_dvd_reg <= {div_dvd_reg[46:0], div_ge};
          if (div_last) begin
            div_state_reg <= SIO_DIV_IDLE;
          end
        end
        default: begin
          div_state_reg <= SIO_DIV_IDLE;
        end
      endcase
    end
  end

  // Register port decode
  assign dec_flow1 = sio_pair_dec(i_reg_addr, SIO_ADDR_FLOW_IN1); // [R18]
  assign dec_flow2 = sio_pair_dec(i_reg_addr, SIO_ADDR_FLOW_IN2); // [R18]
  assign dec_cons1 = sio_pair_dec(i_reg_addr, SIO_ADDR_CONS_IN1);
  assign dec_cons2 = sio_pair_dec(i_reg_addr, SIO_ADDR_CONS_IN2);
  assign dec_ops1 = sio_pair_dec(i_reg_addr, SIO_ADDR_OPS_IN1);
  assign dec_ops2 = sio_pair_dec(i_reg_addr, SIO_ADDR_OPS_IN2);
  assign dec_hours = sio_pair_dec(i_reg_addr, SIO_ADDR_HOURS_IN1);
  assign det_off = i_reg_addr - SIO_ADDR_DETAIL_BASE;
  assign det_ch = 3'(det_off / SIO_DETAIL_STRIDE);
  assign det_sub = 6'(det_off % SIO_DETAIL_STRIDE);
  assign det_hit = (i_reg_addr >= SIO_ADDR_DETAIL_BASE)
    && (det_off < 16'(SIO_CHANNELS) * SIO_DETAIL_STRIDE)
    && (det_sub == SIO_DETAIL_WEIGHT_IN1 || det_sub == SIO_DETAIL_WEIGHT_IN2);
  assign ops_hit = dec_ops1[4] || dec_ops2[4];
  assign ops_idx = dec_ops1[4] ? {1'b0, dec_ops1[3:1]} : 4'({1'b0, dec_ops2[3:1]} + 4'h7);
  assign ops_lsw = dec_ops1[4] ? dec_ops1[0] : dec_ops2[0];

  // Counters and weights
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_hi_reg <= 16'h0000;
      for (int i = 0; i < SIO_INPUTS; i++) begin
        ops_reg[i] <= SIO_COUNTER_RESET;
        weight_reg[i] <= SIO_WEIGHT_RESET; // [R11]
        flow_reg[i] <= 32'h0000_0000;
      end
      for (int c = 0; c < SIO_CHANNELS; c++) begin
        hours_reg[c] <= SIO_COUNTER_RESET;
        secs_reg[c] <= 12'h000;
      end
    end else begin
      if (i_reg_wr) begin
        wr_hi_reg <= i_reg_wdata; // [R19]
      end
      for (int i = 0; i < SIO_INPUTS; i++) begin
        if (i_reg_wr && ops_hit && ops_lsw && ops_idx == 4'(i)) begin
          ops_reg[i] <= {wr_hi_reg, i_reg_wdata}; // [R15] [R19]
        end else if (falling[i]) begin
          ops_reg[i] <= ops_reg[i] + 32'h0000_0001; // [R16]
        end
        if (div_last && div_sel_reg == 4'(i) && !flow_clear[i]) begin
          flow_reg[i] <= sio_to_float(div_quot); // [R10]
        end else if (flow_clear[i] && !falling[i]) begin
          flow_reg[i] <= 32'h0000_0000; // [R12] [R13]
        end
      end
      if (i_reg_wr && det_hit) begin
        weight_reg[(det_sub == SIO_DETAIL_WEIGHT_IN2) ? 4'(det_ch) + 4'h7 : 4'(det_ch)]
          <= i_reg_wdata; // [R11]
      end
      for (int c = 0; c < SIO_CHANNELS; c++) begin
        if (i_reg_wr && dec_hours[4] && dec_hours[0] && dec_hours[3:1] == 3'(c)) begin
          hours_reg[c] <= {wr_hi_reg, i_reg_wdata}; // [R19]
          secs_reg[c] <= 12'h000;
        end else if (sec_tick && sense_reg[c]) begin
          secs_reg[c] <= (secs_reg[c] == SIO_SEC_PER_HOUR_M1) ? 12'h000
            : secs_reg[c] + 12'h001; // [R17]
          if (secs_reg[c] == SIO_SEC_PER_HOUR_M1) begin
            hours_reg[c] <= hours_reg[c] + 32'h0000_0001; // [R17]
          end
        end
      end
    end
  end

  // Read selection
  assign rd_idx = dec_flow1[4] ? {1'b0, dec_flow1[3:1]} :
    dec_flow2[4] ? 4'({1'b0, dec_flow2[3:1]} + 4'h7) :
    dec_cons1[4] ? {1'b0, dec_cons1[3:1]} :
    dec_cons2[4] ? 4'({1'b0, dec_cons2[3:1]} + 4'h7) :
    ops_hit ? ops_idx : {1'b0, dec_hours[3:1]};

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_pair = 1'b1;
    rd_lsw = 1'b0;
    rd_single = 1'b0;
    rd_word = 16'h0000;
    if (dec_flow1[4] || dec_flow2[4]) begin
      rd_val = flow_reg[rd_idx]; // [R10]
      rd_lsw = dec_flow1[4] ? dec_flow1[0] : dec_flow2[0];
    end else if (dec_cons1[4] || dec_cons2[4]) begin
      rd_val = 32'(ops_reg[rd_idx] * {16'h0000, weight_reg[rd_idx]}); // [R14]
      rd_lsw = dec_cons1[4] ? dec_cons1[0] : dec_cons2[0];
    end else if (ops_hit) begin
      rd_val = ops_reg[rd_idx];
      rd_lsw = ops_lsw;
    end else if (dec_hours[4]) begin
      rd_val = hours_reg[rd_idx[2:0]];
      rd_lsw = dec_hours[0];
    end else begin
      rd_pair = 1'b0;
      rd_single = 1'b1;
      case (i_reg_addr)
        SIO_ADDR_IN1_LEVELS: rd_word = {9'h000, sense_reg[6:0]}; // [R01] [R03]
        SIO_ADDR_IN2_LEVELS: rd_word = {9'h000, sense_reg[13:7]}; // [R02] [R03]
        SIO_ADDR_OPEN_MAP: rd_word = {9'h000, open_reg};
        SIO_ADDR_CLOSE_MAP: rd_word = {9'h000, close_reg};
        SIO_ADDR_DEACT_MAP: rd_word = {9'h000, deact_reg};
        SIO_ADDR_ACT_MAP: rd_word = {9'h000, act_reg};
        default: rd_word = det_hit ?
          weight_reg[(det_sub == SIO_DETAIL_WEIGHT_IN2) ? 4'(det_ch) + 4'h7 : 4'(det_ch)]
          : 16'h0000;
      endcase
    end
  end

  // High word read snapshots low word
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
      rd_lo_reg <= 16'h0000;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        if (rd_pair && !rd_lsw) begin
          o_reg_rdata <= rd_val[31:16]; // [R19]
          rd_lo_reg <= rd_val[15:0]; // [R19]
        end else if (rd_pair) begin
          o_reg_rdata <= rd_lo_reg; // [R19]
        end else begin
          o_reg_rdata <= rd_single ? rd_word : 16'h0000;
        end
      end
    end
  end

endmodule : sio_chan_io

// ### tb/sio_chan_io_checker.sv
// Purpose: Port assertions of the I/O block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Order checks watch channel 1 and channel 7 only.
`timescale 1ns/10ps
module sio_chan_io_checker
  import sio_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Channel terminals
  input wire logic [6:0] i_first_sense_input,
  input wire logic [6:0] i_second_sense_input,
  input wire logic [6:0] i_product_present,
  input wire logic i_supply_loss,
  input wire logic [6:0] o_command_q,
  // Register port
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [15:0] o_reg_rdata
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  // Channel 1 order write, then idle
  sequence s_order_ch0(logic [15:0] a);
    i_reg_wr && i_reg_addr == a && i_reg_wdata[0] && i_product_present[0]
      ##1 !i_reg_wr && i_product_present[0];
  endsequence
  sequence s_read(logic [15:0] a);
    i_reg_rd && i_reg_addr == a;
  endsequence

  property p_first_levels;
    ($stable(i_first_sense_input) [*4]) ##0 s_read(SIO_ADDR_IN1_LEVELS)
      |=> o_reg_rdata == {9'h000, $past(i_first_sense_input)};
  endproperty
  a_first_levels: assert property (p_first_levels) else $error("in1 levels");
  property p_second_levels;
    ($stable(i_second_sense_input) [*4]) ##0 s_read(SIO_ADDR_IN2_LEVELS)
      |=> o_reg_rdata == {9'h000, $past(i_second_sense_input)};
  endproperty
  a_second_levels: assert property (p_second_levels) else $error("in2 levels");
  property p_order_reserved;
    i_reg_rd && i_reg_addr >= SIO_ADDR_OPEN_MAP && i_reg_addr <= SIO_ADDR_ACT_MAP
      |=> o_reg_rdata[15:7] == 9'h000;
  endproperty
  a_order_reserved: assert property (p_order_reserved) else $error("reserved bit set");
  property p_close_sets;
    s_order_ch0(SIO_ADDR_CLOSE_MAP) |=> o_command_q[0];
  endproperty
  a_close_sets: assert property (p_close_sets) else $error("close order not done");
  property p_open_clears;
    s_order_ch0(SIO_ADDR_OPEN_MAP) |=> !o_command_q[0];
  endproperty
  a_open_clears: assert property (p_open_clears) else $error("open order not done");
  property p_act_sets;
    s_order_ch0(SIO_ADDR_ACT_MAP) |=> o_command_q[0];
  endproperty
  a_act_sets: assert property (p_act_sets) else $error("activate not done");
  property p_deact_clears;
    s_order_ch0(SIO_ADDR_DEACT_MAP) |=> !o_command_q[0];
  endproperty
  a_deact_clears: assert property (p_deact_clears) else $error("deactivate not done");
  property p_absent_holds;
    (!i_product_present[6]) [*3] |-> $stable(o_command_q[6]);
  endproperty
  a_absent_holds: assert property (p_absent_holds) else $error("Q moved");
  property p_supply_flow;
    (i_supply_loss [*3]) ##0 s_read(SIO_ADDR_FLOW_IN1) |=> o_reg_rdata == 16'h0000;
  endproperty
  a_supply_flow: assert property (p_supply_flow) else $error("flow kept");
endmodule : sio_chan_io_checker

bind sio_chan_io sio_chan_io_checker u_checker (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_first_sense_input(i_first_sense_input),
  .i_second_sense_input(i_second_sense_input), .i_product_present(i_product_present),
  .i_supply_loss(i_supply_loss), .o_command_q(o_command_q), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata)
);

// ### tb/sio_field_model.sv
// Purpose: Field side of the channels: one pulse meter and breaker contacts.
// Assumes: Same clock as the block.
// Notes: Contacts follow the command output two cycles late.
`timescale 1ns/10ps
module sio_field_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Block side
  input wire logic [6:0] i_command_q,
  input wire logic i_pulse_req,
  output logic o_meter_out,
  output logic [6:0] o_aux_contact
);
  logic [3:0] low_reg;
  logic [6:0] delay_reg;
  // Meter idles high, a pulse pulls it low for ten cycles
  assign o_meter_out = (low_reg == 4'h0);
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      low_reg <= 4'h0;
      delay_reg <= 7'h00;
      o_aux_contact <= 7'h00;
    end else begin
      if (i_pulse_req) low_reg <= 4'hA;
      else if (low_reg != 4'h0) low_reg <= low_reg - 4'h1;
      delay_reg <= i_command_q;
      o_aux_contact <= delay_reg;
    end
  end
endmodule : sio_field_model

// ### tb/test_seven_channel_io_pulse_counters.sv
// Purpose: Self-checking bench for the seven-channel I/O block.
// Assumes: One millisecond shortened to five cycles.
// Notes: Reads queue expectations; a monitor compares.
`timescale 1ns/10ps
module test_seven_channel_io_pulse_counters;
  import sio_pkg::*;
  localparam int MS = 5;
  localparam logic [15:0] W1 = SIO_ADDR_DETAIL_BASE + {10'h000, SIO_DETAIL_WEIGHT_IN1};
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [6:0] levels = 7'h00;
  logic [6:0] i_product_present = 7'h3F;
  logic i_supply_loss = 1'b0;
  logic [15:0] i_reg_addr = 16'h0000;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic pulse_req = 1'b0;
  logic meter_out, o_reg_rvalid;
  logic [6:0] aux, o_command_q;
  logic [15:0] o_reg_rdata;
  logic [15:0] exp_q[$];
  logic [7:0] rnd = 8'h40;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #10 i_sys_clk = ~i_sys_clk;

  sio_chan_io #(.MS_CYCLES(MS)) uut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_first_sense_input({levels[6:1], meter_out}),
    .i_second_sense_input(aux), .i_product_present(i_product_present),
    .i_supply_loss(i_supply_loss), .o_command_q(o_command_q), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid));
  sio_field_model u_field (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_command_q(o_command_q),
    .i_pulse_req(pulse_req), .o_meter_out(meter_out), .o_aux_contact(aux));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Integer to float32 with truncated mantissa
  function automatic logic [31:0] to_f(input logic [31:0] n);
    int e;
    logic [31:0] m;
    if (n == 32'h0000_0000) return 32'h0000_0000;
    e = 31;
    while (n[e] == 1'b0) e--;
    m = (e > 23) ? (n >> (e - 23)) : (n << (23 - e));
    return {1'b0, 8'(127 + e), m[22:0]};
  endfunction : to_f
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge i_sys_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_sys_clk);
    i_reg_wr = 1'b0;
    @(negedge i_sys_clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge i_sys_clk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
    @(negedge i_sys_clk);
  endtask : rd
  task automatic rd32(input logic [15:0] a, input logic [31:0] e);
    rd(a, e[31:16]);
    rd(a + 16'h0001, e[15:0]);
  endtask : rd32
  task automatic pulse(input int gap);
    @(negedge i_sys_clk);
    pulse_req = 1'b1;
    @(negedge i_sys_clk);
    pulse_req = 1'b0;
    repeat (gap) @(posedge i_sys_clk);
  endtask : pulse
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  always @(negedge i_sys_clk) begin
    if (o_reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) check("unasked read", 16'h0001, 16'h0000);
      else check("rdata", o_reg_rdata, exp_q.pop_front());
    end
  end
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      $display("run timed out");
      give_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    for (int a = 0; a < 4; a++) rd(SIO_ADDR_OPEN_MAP + 16'(a), SIO_ORDER_RESET);
    rd(W1, SIO_WEIGHT_RESET);
    rd32(SIO_ADDR_OPS_IN1, SIO_COUNTER_RESET);
    rd(16'h0010, 16'h0000);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      levels = rnd[6:0];
      repeat (3) @(posedge i_sys_clk);
      rd(SIO_ADDR_IN1_LEVELS, {9'h000, rnd[6:1], 1'b1});
      rd(SIO_ADDR_IN2_LEVELS, 16'h0000);
    end
    $display("levels done");
    wr(SIO_ADDR_CLOSE_MAP, 16'hFFFF);
    repeat (4) @(posedge i_sys_clk);
    check("command", {9'h000, o_command_q}, 16'h003F);
    rd(SIO_ADDR_CLOSE_MAP, 16'h0040);
    rd(SIO_ADDR_IN2_LEVELS, 16'h003F);
    wr(SIO_ADDR_OPEN_MAP, 16'h0015);
    check("command", {9'h000, o_command_q}, 16'h002A);
    wr(SIO_ADDR_DEACT_MAP, 16'h0003);
    check("command", {9'h000, o_command_q}, 16'h0028);
    wr(SIO_ADDR_ACT_MAP, 16'h0001);
    check("command", {9'h000, o_command_q}, 16'h0029);
    wr(SIO_ADDR_OPEN_MAP, 16'h0040);
    rd(SIO_ADDR_OPEN_MAP, 16'h0040);
    i_product_present = 7'h7F;
    repeat (4) @(posedge i_sys_clk);
    check("command", {9'h000, o_command_q}, 16'h0029);
    rd(SIO_ADDR_OPEN_MAP, 16'h0000);
    rd(SIO_ADDR_CLOSE_MAP, 16'h0000);
    $display("orders done");
    repeat (3) pulse(100 * MS - 1);
    rd32(SIO_ADDR_OPS_IN1, 32'h0000_0003);
    rd32(SIO_ADDR_CONS_IN1, 32'h0000_001E);
    rd32(SIO_ADDR_FLOW_IN1, to_f(32'(SIO_FLOW_SCALE * 10 / 100)));
    wr(SIO_ADDR_OPS_IN1, 16'h0001);
    wr(SIO_ADDR_OPS_IN1 + 16'h0001, 16'h0000);
    pulse(20);
    rd32(SIO_ADDR_OPS_IN1, 32'h0001_0001);
    wr(W1, 16'h0003);
    rd32(SIO_ADDR_CONS_IN1, 32'h0003_0003);
    i_supply_loss = 1'b1;
    repeat (5) @(posedge i_sys_clk);
    rd32(SIO_ADDR_FLOW_IN1, 32'h0000_0000);
    i_supply_loss = 1'b0;
    repeat (2) pulse(100 * MS - 1);
    rd32(SIO_ADDR_FLOW_IN1, to_f(32'(SIO_FLOW_SCALE * 3 / 100)));
    repeat (2000 * MS) @(posedge i_sys_clk);
    rd32(SIO_ADDR_FLOW_IN1, to_f(32'(SIO_FLOW_SCALE * 3 / 100)));
    repeat (3100 * MS) @(posedge i_sys_clk);
    rd32(SIO_ADDR_FLOW_IN1, 32'h0000_0000);
    $display("counters and flow done");
    rnd = lfsr(rnd);
    wr(SIO_ADDR_HOURS_IN1, {8'h00, rnd});
    wr(SIO_ADDR_HOURS_IN1 + 16'h0001, 16'h1234);
    rd32(SIO_ADDR_HOURS_IN1, {8'h00, rnd, 16'h1234});
    $display("hours done");
    repeat (4) @(negedge i_sys_clk);
    if (exp_q.size() != 0) check("pending reads", 16'(exp_q.size()), 16'h0000);
    give_verdict();
  end
endmodule : test_seven_channel_io_pulse_counters
